/* File: rtl/mcd_params.svh */
// constants for the microcoded datapath timing block
// assumes one 10 MHz clock (hclk) and an AHB-Lite slave port
`ifndef MCD_PARAMS_SVH
`define MCD_PARAMS_SVH
`define MCD_CLK_PERIOD_NS 100
// pulse spacing in ns for the three cycle lengths
`define MCD_LEN_SHORT_NS 200
`define MCD_LEN_MEDIUM_NS 300
`define MCD_LEN_LONG_NS 400
`define MCD_LEN_SHORT_CYC ((`MCD_LEN_SHORT_NS + `MCD_CLK_PERIOD_NS - 1) / `MCD_CLK_PERIOD_NS)
`define MCD_LEN_MEDIUM_CYC ((`MCD_LEN_MEDIUM_NS + `MCD_CLK_PERIOD_NS - 1) / `MCD_CLK_PERIOD_NS)
`define MCD_LEN_LONG_CYC ((`MCD_LEN_LONG_NS + `MCD_CLK_PERIOD_NS - 1) / `MCD_CLK_PERIOD_NS)
// register byte offsets
`define MCD_REG_CTRL 8'h00
`define MCD_REG_STATUS 8'h04
`define MCD_REG_SWITCH 8'h08
`define MCD_REG_STACK_LIMIT 8'h0c
`define MCD_REG_INSTR 8'h10
`define MCD_REG_RESULT 8'h14
`define MCD_REG_PREV_UPTR 8'h18
`define MCD_REG_DISPLAY 8'h1c
// ctrl fields
`define MCD_CTRL_MATCH_STOP 0
`define MCD_CTRL_RESTART 1
`define MCD_CTRL_CONTINUE 2
// status fields
`define MCD_ST_RUN 0
`define MCD_ST_IDLE 1
`define MCD_ST_MATCH 2
`define MCD_ST_ZERO 3
`define MCD_ST_OVFL 4
`define MCD_ST_OVFL_HALT 5
// address decode: processor register page and offsets
`define MCD_IOPAGE_BASE 18'h3ff00
`define MCD_ADR_STATUS 8'hfe
`define MCD_ADR_STACK_LIMIT 8'hfa
`define MCD_ADR_SWITCH 8'h78
`define MCD_ADR_SCRATCH_LO 8'hc0
`define MCD_ADR_SCRATCH_HI 8'hdf
// stack red zone: addresses below this are overflow
`define MCD_STACK_FLOOR 18'h00100
`define MCD_STACK_RED 18'h000e0
`endif

/* File: rtl/mcd_pkg.sv */
// types for the microcoded datapath timing block
// assumes the params header supplies all numbers
package mcd_pkg;
    typedef enum logic [1:0] {
        mcd_sel_read_bus,
        mcd_sel_result,
        mcd_sel_result_shr,
        mcd_sel_bus_data
    } mcd_dsel_type;
    typedef enum logic [2:0] {
        mcd_ph_idle,
        mcd_ph_first,
        mcd_ph_second,
        mcd_ph_third,
        mcd_ph_recycle
    } mcd_phase_type;
endpackage

/* File: rtl/mcd_datapath.sv */
// microcoded datapath timing: clock control, pulse generator, enable gates,
// result select mux, result and instruction registers, decode, match.
// assumes the control store and bus drive inputs on hclk; ahb-lite slave.
`include "mcd_params.svh"

// Behaviour
// - match is set when buffered micro-pointer equals switch bits 8:0
// - match with match-stop set halts clock; else drives scope sync out
// - run and idle flops; halt bit stops pulses; restart or continue resumes
// - two length select bits choose one of three cycle lengths
// - each cycle emits three ordered pulses then a recycle pulse
// - pulse reaches a destination only when its microword enable is set
// - 2-bit field selects exactly one of four 16-bit mux sources
// - sources: read bus, result reg, result shifted right, bus data
// - mux output feeds instruction, scratch, operand b, status, display, options
// - 16-bit result register loads alu output when its enable is gated
// - result register drives mux and the sixteen bus data lines
// - console data indicators show inverse of mux output
// - 18-bit address decode selects status, stack limit, scratch, switch
// - address below stack floor raises overflow flag; below the red zone also halt
// - zero indication when all result register bits are zero
// - micro-pointer buffered to history register and expansion copy
// - 16-bit instruction register loads from mux during fetch
// - instruction feeds decoder; bits go to branch tests and scratch select
// - history register captures micro-pointer every microcycle
module mcd_datapath #(
    parameter int UPTR_W = 9,
    parameter int DATA_W = 16,
    parameter int ADDR_W = 18
) (
    // clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // microword fields
    input wire logic [UPTR_W-1:0] micro_pointer,
    input wire logic clock_halt_bit,
    input wire logic pulse_length_sel0,
    input wire logic pulse_length_sel1,
    input wire logic [1:0] result_sel,
    input wire logic load_instr_enable,
    input wire logic load_addr_enable,
    input wire logic load_operand_b_enable,
    input wire logic load_result_enable,
    input wire logic write_high_byte,
    input wire logic write_low_byte,
    // data sources
    input wire logic [DATA_W-1:0] read_bus,
    input wire logic [DATA_W-1:0] alu_out,
    input wire logic [DATA_W-1:0] bus_data_in,
    input wire logic [ADDR_W-1:0] bus_address,
    // timing outputs
    output logic phase_pulse_first,
    output logic phase_pulse_second,
    output logic phase_pulse_third,
    output logic recycle_pulse,
    output logic scope_sync,
    // gated destination clocks
    output logic instr_clk,
    output logic addr_clk,
    output logic operand_b_clk,
    output logic result_clk,
    output logic write_high_clk,
    output logic write_low_clk,
    // data outputs
    output logic [DATA_W-1:0] result_select_mux,
    output logic [DATA_W-1:0] bus_data_out,
    output logic [DATA_W-1:0] data_display_n,
    output logic [DATA_W-1:0] instruction_holder,
    output logic [UPTR_W-1:0] previous_micro_pointer,
    output logic [UPTR_W-1:0] expansion_micro_pointer,
    output logic [3:0] scratch_sel,
    // decode outputs
    output logic sel_processor_status,
    output logic sel_stack_limit_reg,
    output logic sel_scratch,
    output logic sel_switch,
    output logic stack_overflow_flag,
    output logic stack_overflow_halt,
    output logic result_zero
);
    localparam logic [2:0] LEN_S = 3'(`MCD_LEN_SHORT_CYC);
    localparam logic [2:0] LEN_M = 3'(`MCD_LEN_MEDIUM_CYC);
    localparam logic [2:0] LEN_L = 3'(`MCD_LEN_LONG_CYC);

    // register file state
    logic [DATA_W-1:0] console_switch_value_q;
    logic [ADDR_W-1:0] stack_limit_reg_q;
    logic match_stop_q;
    // restart and continue are one-cycle strobes from a ctrl write
    logic restart_q;
    logic continue_q;

    logic [DATA_W-1:0] result_q;
    logic [DATA_W-1:0] instr_q;
    logic [UPTR_W-1:0] buffered_micro_pointer;

    // clock control flops
    logic run_q;
    logic idle_q;
    logic match_hold_q;

    // pulse sequencer state
    mcd_pkg::mcd_phase_type phase_q;
    mcd_pkg::mcd_phase_type phase_d;
    logic [2:0] cnt_q;
    // length latched at the first pulse so a word change cannot stretch a gap
    logic [2:0] len_q;

    // ahb state
    logic wr_pend_q;
    logic [7:0] adr_q;

    assign buffered_micro_pointer = micro_pointer;

    wire match_w = &(~(buffered_micro_pointer ^ console_switch_value_q[UPTR_W-1:0]));

    wire [2:0] len_w = pulse_length_sel1 ? LEN_L : (pulse_length_sel0 ? LEN_M : LEN_S);

    wire [DATA_W-1:0] shr_w = {1'b0, result_q[DATA_W-1:1]};
    wire [DATA_W-1:0] mux_w =
        (result_sel == 2'(mcd_pkg::mcd_sel_read_bus)) ? read_bus :
        (result_sel == 2'(mcd_pkg::mcd_sel_result)) ? result_q :
        (result_sel == 2'(mcd_pkg::mcd_sel_result_shr)) ? shr_w : bus_data_in;

    // address decode
    // processor registers live in the top page of the address space
    localparam logic [ADDR_W-1:0] PAGE_BASE = `MCD_IOPAGE_BASE;
    wire page_w = (bus_address[ADDR_W-1:8] == PAGE_BASE[ADDR_W-1:8]);
    wire [7:0] low_w = bus_address[7:0];
    wire sel_ps_w = page_w && (low_w == `MCD_ADR_STATUS);
    wire sel_slr_w = page_w && (low_w == `MCD_ADR_STACK_LIMIT);
    wire sel_sw_w = page_w && (low_w == `MCD_ADR_SWITCH);
    wire sel_reg_w = page_w && (low_w >= `MCD_ADR_SCRATCH_LO) && (low_w <= `MCD_ADR_SCRATCH_HI);
    // overflow sense
    // the halt zone sits below the flag zone, so halt implies flag unless floor plus limit wraps past 18 bits
    wire ovfl_w = (bus_address < (`MCD_STACK_FLOOR + stack_limit_reg_q));
    wire ovfl_halt_w = (bus_address < stack_limit_reg_q + `MCD_STACK_RED);

    // phase timing
    // counter reaches one on the last cycle of each gap
    wire tick_w = (cnt_q == 3'd1);
    wire go_w = run_q && !match_hold_q;

    // idle, three pulse phases, then one recycle phase
    always_comb begin
        phase_d = phase_q;
        case (phase_q)
            mcd_pkg::mcd_ph_idle: if (go_w) phase_d = mcd_pkg::mcd_ph_first;
            mcd_pkg::mcd_ph_first: if (tick_w) phase_d = mcd_pkg::mcd_ph_second;
            mcd_pkg::mcd_ph_second: if (tick_w) phase_d = mcd_pkg::mcd_ph_third;
            mcd_pkg::mcd_ph_third: if (tick_w) phase_d = mcd_pkg::mcd_ph_recycle;
            mcd_pkg::mcd_ph_recycle: phase_d = mcd_pkg::mcd_ph_idle;
            default: phase_d = mcd_pkg::mcd_ph_idle;
        endcase
    end

    // a pulse marks the entry into its phase
    wire p1_w = (phase_q != mcd_pkg::mcd_ph_first) && (phase_d == mcd_pkg::mcd_ph_first);
    wire p2_w = (phase_q != mcd_pkg::mcd_ph_second) && (phase_d == mcd_pkg::mcd_ph_second);
    wire p3_w = (phase_q != mcd_pkg::mcd_ph_third) && (phase_d == mcd_pkg::mcd_ph_third);
    // recycle follows the last gap of the third phase
    wire rc_w = (phase_q == mcd_pkg::mcd_ph_third) && tick_w;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_q <= mcd_pkg::mcd_ph_idle;
            cnt_q <= 3'h0;
            len_q <= 3'h1;
        end else if (clk_en) begin
            phase_q <= phase_d;
            if (p1_w) begin
                len_q <= len_w;
                cnt_q <= len_w;
            end else if (p2_w || p3_w) begin
                cnt_q <= len_q;
            end else if (cnt_q != 3'h0) begin
                cnt_q <= cnt_q - 3'h1;
            end
        end
    end

    // run and idle control
    // a restart or continue beats a halt bit seen in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_q <= 1'b1;
            idle_q <= 1'b0;
        end else if (clk_en) begin
            if (restart_q || continue_q) begin
                run_q <= 1'b1;
            end else if (rc_w && clock_halt_bit) begin
                run_q <= 1'b0;
            end
            idle_q <= (phase_d == mcd_pkg::mcd_ph_idle) && !go_w;
        end
    end

    // match stop at cycle end
    // a new stop wins over a continue arriving in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            match_hold_q <= 1'b0;
        end else if (clk_en) begin
            if (rc_w && match_w && match_stop_q) begin
                match_hold_q <= 1'b1;
            end else if (continue_q || restart_q) begin
                match_hold_q <= 1'b0;
            end
        end
    end

    // gated loads
    // loads happen on the pulse edge while the microword is held steady
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_q <= '0;
            instr_q <= '0;
            previous_micro_pointer <= '0;
        end else if (clk_en) begin
            if (p3_w && load_result_enable) result_q <= alu_out;
            if (p2_w && load_instr_enable) instr_q <= mux_w;
            if (p1_w) previous_micro_pointer <= buffered_micro_pointer;
        end
    end


    // registered outputs
    // every port comes from a flop; pulses and gated clocks last one cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_pulse_first <= 1'b0;
            phase_pulse_second <= 1'b0;
            phase_pulse_third <= 1'b0;
            recycle_pulse <= 1'b0;
            scope_sync <= 1'b0;
            instr_clk <= 1'b0;
            addr_clk <= 1'b0;
            operand_b_clk <= 1'b0;
            result_clk <= 1'b0;
            write_high_clk <= 1'b0;
            write_low_clk <= 1'b0;
            result_select_mux <= '0;
            bus_data_out <= '0;
            data_display_n <= '1;
            instruction_holder <= '0;
            expansion_micro_pointer <= '0;
            scratch_sel <= 4'h0;
            sel_processor_status <= 1'b0;
            sel_stack_limit_reg <= 1'b0;
            sel_scratch <= 1'b0;
            sel_switch <= 1'b0;
            stack_overflow_flag <= 1'b0;
            stack_overflow_halt <= 1'b0;
            result_zero <= 1'b1;
        end else if (clk_en) begin
            phase_pulse_first <= p1_w;
            phase_pulse_second <= p2_w;
            phase_pulse_third <= p3_w;
            recycle_pulse <= rc_w;
            scope_sync <= match_w && !match_stop_q;
            instr_clk <= p2_w && load_instr_enable;
            addr_clk <= p1_w && load_addr_enable;
            operand_b_clk <= p2_w && load_operand_b_enable;
            result_clk <= p3_w && load_result_enable;
            write_high_clk <= p3_w && write_high_byte;
            write_low_clk <= p3_w && write_low_byte;
            result_select_mux <= mux_w;
            bus_data_out <= result_q;
            data_display_n <= ~mux_w;
            instruction_holder <= instr_q;
            scratch_sel <= {1'b0, instr_q[2:0]};
            expansion_micro_pointer <= buffered_micro_pointer;
            sel_processor_status <= sel_ps_w;
            sel_stack_limit_reg <= sel_slr_w;
            sel_scratch <= sel_reg_w;
            sel_switch <= sel_sw_w;
            stack_overflow_flag <= ovfl_w;
            stack_overflow_halt <= ovfl_halt_w;
            result_zero <= (result_q == '0);
        end
    end


    // ahb-lite slave, zero wait states, always okay
    // a read right behind a write to the same word sees the old value
    wire ahb_go_w = hsel && hready && htrans[1];
    wire [31:0] status_w = {26'h0, stack_overflow_halt, stack_overflow_flag, result_zero,
                            match_w, idle_q, run_q};
    logic [31:0] rd_mux_w;

    // read select follows the address phase so data is ready for the data phase
    always_comb begin
        case (haddr[7:0])
            `MCD_REG_CTRL: rd_mux_w = {29'h0, 2'b00, match_stop_q};
            `MCD_REG_STATUS: rd_mux_w = status_w;
            `MCD_REG_SWITCH: rd_mux_w = {16'h0, console_switch_value_q};
            `MCD_REG_STACK_LIMIT: rd_mux_w = {14'h0, stack_limit_reg_q};
            `MCD_REG_INSTR: rd_mux_w = {16'h0, instr_q};
            `MCD_REG_RESULT: rd_mux_w = {16'h0, result_q};
            `MCD_REG_PREV_UPTR: rd_mux_w = {23'h0, previous_micro_pointer};
            `MCD_REG_DISPLAY: rd_mux_w = {16'h0, data_display_n};
            default: rd_mux_w = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            adr_q <= 8'h0;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (clk_en) begin
            wr_pend_q <= ahb_go_w && hwrite;
            if (ahb_go_w) adr_q <= haddr[7:0];
            // captured at the address phase, stands through the data phase
            if (ahb_go_w && !hwrite) hrdata <= rd_mux_w;
        end
    end

    // software registers
    // writes land at the end of the data phase, when hwdata stands
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            console_switch_value_q <= '0;
            stack_limit_reg_q <= '0;
            match_stop_q <= 1'b0;
            restart_q <= 1'b0;
            continue_q <= 1'b0;
        end else if (clk_en) begin
            restart_q <= 1'b0;
            continue_q <= 1'b0;
            if (wr_pend_q) begin
                case (adr_q)
                    `MCD_REG_CTRL: begin
                        match_stop_q <= hwdata[`MCD_CTRL_MATCH_STOP];
                        restart_q <= hwdata[`MCD_CTRL_RESTART];
                        continue_q <= hwdata[`MCD_CTRL_CONTINUE];
                    end
                    `MCD_REG_SWITCH: console_switch_value_q <= hwdata[DATA_W-1:0];
                    `MCD_REG_STACK_LIMIT: stack_limit_reg_q <= hwdata[ADDR_W-1:0];
                    default: ;
                endcase
            end
        end
    end
endmodule

/* File: bench/mcd_monitor.sv */
// checker on the datapath ports: pulse timing, gating, mux, decode
// assumes the microword inputs hold steady for a whole microcycle
`include "mcd_params.svh"
module mcd_monitor #(
    parameter int UPTR_W = 9,
    parameter int DATA_W = 16,
    parameter int ADDR_W = 18
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // microword and data inputs
    input wire logic [UPTR_W-1:0] micro_pointer,
    input wire logic pulse_length_sel0,
    input wire logic pulse_length_sel1,
    input wire logic [1:0] result_sel,
    input wire logic load_instr_enable,
    input wire logic load_addr_enable,
    input wire logic load_operand_b_enable,
    input wire logic write_high_byte,
    input wire logic write_low_byte,
    input wire logic [DATA_W-1:0] read_bus,
    input wire logic [DATA_W-1:0] alu_out,
    input wire logic [ADDR_W-1:0] bus_address,
    // design outputs
    input wire logic phase_pulse_first,
    input wire logic phase_pulse_second,
    input wire logic phase_pulse_third,
    input wire logic instr_clk,
    input wire logic addr_clk,
    input wire logic operand_b_clk,
    input wire logic write_high_clk,
    input wire logic write_low_clk,
    input wire logic result_clk,
    input wire logic [DATA_W-1:0] result_select_mux,
    input wire logic [DATA_W-1:0] bus_data_out,
    input wire logic [DATA_W-1:0] data_display_n,
    input wire logic [UPTR_W-1:0] previous_micro_pointer,
    input wire logic [UPTR_W-1:0] expansion_micro_pointer,
    input wire logic sel_processor_status,
    input wire logic stack_overflow_flag,
    input wire logic stack_overflow_halt
);
    default clocking mon_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    len_short_a:
    assert property (phase_pulse_first && !pulse_length_sel1 && !pulse_length_sel0
        |-> ##2 phase_pulse_second) else $error("short spacing wrong");
    len_long_a:
    assert property (phase_pulse_first && pulse_length_sel1 |-> ##4 phase_pulse_second)
        else $error("long spacing wrong");
    pulse_order_a:
    assert property (phase_pulse_second |-> ##[2:4] phase_pulse_third)
        else $error("third pulse missing");
    instr_gate_a:
    assert property (instr_clk == (phase_pulse_second && load_instr_enable))
        else $error("instruction clock gating wrong");
    gate_rest_a:
    assert property (addr_clk == (phase_pulse_first && load_addr_enable)
        && operand_b_clk == (phase_pulse_second && load_operand_b_enable)
        && write_high_clk == (phase_pulse_third && write_high_byte)
        && write_low_clk == (phase_pulse_third && write_low_byte))
        else $error("destination clock gating wrong");
    mux_read_a:
    assert property ($past(hresetn) && $past(result_sel) == 2'h0
        |-> result_select_mux == $past(read_bus)) else $error("read bus not selected");
    display_inv_a:
    assert property (data_display_n == ~result_select_mux)
        else $error("display not inverted");
    result_load_a:
    assert property (result_clk |-> ##[0:2] bus_data_out == alu_out)
        else $error("result not loaded");
    history_a:
    assert property (phase_pulse_second |-> previous_micro_pointer == micro_pointer
        && expansion_micro_pointer == micro_pointer) else $error("pointer copy wrong");
    status_dec_a:
    assert property ($past(hresetn)
        && $past(bus_address) == (`MCD_IOPAGE_BASE | `MCD_ADR_STATUS)
        |-> sel_processor_status) else $error("status address missed");
    red_zone_a:
    assert property (stack_overflow_halt |-> stack_overflow_flag)
        else $error("halt without flag");
endmodule

/* File: bench/mcd_store_model.sv */
// store model: microword source and bus data for the datapath
// assumes the bench offers the next word; it is taken at each recycle
module mcd_store_model (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // next word
    input wire logic recycle_pulse,
    input wire logic [10:0] nxt_ctl,
    input wire logic [47:0] nxt_dat,
    // word to the datapath
    output logic [8:0] micro_pointer,
    output logic clock_halt_bit,
    output logic pulse_length_sel0,
    output logic pulse_length_sel1,
    output logic [1:0] result_sel,
    output logic load_instr_enable,
    output logic load_addr_enable,
    output logic load_operand_b_enable,
    output logic load_result_enable,
    output logic write_high_byte,
    output logic write_low_byte,
    output logic [15:0] read_bus,
    output logic [15:0] alu_out,
    output logic [15:0] bus_data_in
);
    logic [8:0] ptr_q;
    logic [10:0] ctl_q;
    logic [47:0] dat_q;
    assign micro_pointer = ptr_q;
    assign {write_low_byte, write_high_byte, load_result_enable} = ctl_q[10:8];
    assign {load_operand_b_enable, load_addr_enable, load_instr_enable} = ctl_q[7:5];
    assign {result_sel, pulse_length_sel1, pulse_length_sel0, clock_halt_bit} = ctl_q[4:0];
    assign {read_bus, alu_out, bus_data_in} = dat_q;
    // word held through the microcycle so gating sees one value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ptr_q <= 9'h000;
            ctl_q <= 11'h000;
            dat_q <= 48'h0;
        end else if (recycle_pulse) begin
            ptr_q <= ptr_q + 9'h001;
            ctl_q <= nxt_ctl;
            dat_q <= nxt_dat;
        end
    end
endmodule

/* File: bench/tb_microcoded_datapath_timing.sv */
// bench for the microcoded datapath timing block
// assumes the store model feeds words; registers reached over ahb-lite
`include "mcd_params.svh"
module tb_microcoded_datapath_timing;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, clock_halt_bit, clk_en;
    logic [31:0] haddr, hwdata, hrdata, rdat;
    logic [1:0] htrans, result_sel;
    logic [10:0] nxt_ctl;
    logic [47:0] nxt_dat;
    logic [8:0] tgt, micro_pointer, previous_micro_pointer, expansion_micro_pointer;
    logic [17:0] bus_address;
    logic [3:0] scratch_sel;
    logic pulse_length_sel0, pulse_length_sel1, load_instr_enable, load_addr_enable;
    logic load_operand_b_enable, load_result_enable, write_high_byte, write_low_byte;
    logic phase_pulse_first, phase_pulse_second, phase_pulse_third, recycle_pulse;
    logic scope_sync, instr_clk, addr_clk, operand_b_clk, result_clk, write_high_clk;
    logic write_low_clk, sel_processor_status, sel_stack_limit_reg, sel_scratch;
    logic sel_switch, stack_overflow_flag, stack_overflow_halt, result_zero;
    logic [15:0] read_bus, alu_out, bus_data_in, result_select_mux, bus_data_out;
    logic [15:0] data_display_n, instruction_holder;
    logic [5:0] dec_seen;
    int bad_count = 0, comparisons = 0, cycles = 0, cnt, hits;
    logic [15:0] mux_exp [4] = '{16'h1111, 16'hb5a6, 16'h5ad3, 16'h7e81};
    logic [17:0] dec_adr [7] = '{18'h3fffe, 18'h3fffa, 18'h3ffc5, 18'h3ff78,
        18'h00050, 18'h000f0, 18'h01000};
    logic [5:0] dec_exp [7] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h03, 6'h02, 6'h00};
    assign dec_seen = {sel_processor_status, sel_stack_limit_reg, sel_scratch, sel_switch,
        stack_overflow_flag, stack_overflow_halt};
    mcd_datapath uut (.hsize(3'h2), .hready(hreadyout), .*);
    mcd_store_model u_store (.*);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdat = hrdata;
    endtask
    task automatic wait_rec;
        do @(posedge hclk); while (recycle_pulse !== 1'b1);
    endtask
    task automatic run_word(input logic [10:0] c, input logic [47:0] d);
        nxt_ctl <= c;
        nxt_dat <= d;
        wait_rec;
        wait_rec;
    endtask
    // counts first pulses and scope sync over n cycles
    task automatic watch(input int n);
        cnt = 0;
        hits = 0;
        repeat (n) begin
            @(posedge hclk);
            cnt += int'(phase_pulse_first === 1'b1);
            hits += int'(scope_sync === 1'b1);
        end
    endtask
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            test_done;
        end
    end
    initial begin
        {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
        {nxt_ctl, nxt_dat} = '0;
        clk_en = 1'b1;
        bus_address = 18'h01000;
        repeat (6) @(posedge hclk);
        check(data_display_n, 32'hffff);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 4; i++) begin
            run_word(11'(i << 1), 48'h0);
            do @(posedge hclk); while (phase_pulse_first !== 1'b1);
            cnt = 0;
            do begin @(posedge hclk); cnt++; end while (phase_pulse_second !== 1'b1);
            check(cnt, (i == 0) ? 2 : (i == 1) ? 3 : 4);
        end
        $display("test cycle lengths done");
        for (int s = 0; s < 4; s++) begin
            run_word(11'h780 | 11'(s << 3), {16'h1111, 16'hb5a6, 16'h7e81});
            check(result_select_mux, mux_exp[s]);
            check(data_display_n, 16'(~mux_exp[s]));
            check(bus_data_out, 16'hb5a6);
            check(result_zero, 1'b0);
        end
        run_word(11'h100, 48'h0);
        wait_rec;
        check(result_zero, 1'b1);
        run_word(11'h038, 48'h9c35);
        check(instruction_holder, 16'h9c35);
        check(scratch_sel[2:0], 3'h5);
        ahb(1'b0, {24'h0, `MCD_REG_INSTR}, 32'h0);
        check(rdat, 32'h9c35);
        check(hresp, 1'b0);
        ahb(1'b1, 32'h40, 32'h5a5a);
        ahb(1'b0, 32'h40, 32'h0);
        check(rdat, 32'h0);
        $display("test data paths done");
        tgt = micro_pointer + 9'h002;
        ahb(1'b1, {24'h0, `MCD_REG_SWITCH}, {23'h0, tgt});
        watch(40);
        check(hits != 0, 1'b1);
        tgt = micro_pointer + 9'h003;
        ahb(1'b1, {24'h0, `MCD_REG_SWITCH}, {23'h0, tgt});
        ahb(1'b1, {24'h0, `MCD_REG_CTRL}, 32'h1);
        watch(60);
        watch(30);
        check(cnt, 0);
        check(previous_micro_pointer, tgt);
        ahb(1'b1, {24'h0, `MCD_REG_CTRL}, 32'h4);
        watch(30);
        check(cnt != 0, 1'b1);
        wait_rec;
        clk_en <= 1'b0;
        watch(20);
        clk_en <= 1'b1;
        check(cnt, 0);
        $display("test match stop done");
        nxt_ctl <= 11'h001;
        wait_rec;
        wait_rec;
        nxt_ctl <= 11'h000;
        watch(30);
        check(cnt, 0);
        ahb(1'b0, {24'h0, `MCD_REG_STATUS}, 32'h0);
        check(rdat[`MCD_ST_RUN], 1'b0);
        ahb(1'b1, {24'h0, `MCD_REG_CTRL}, 32'h2);
        watch(30);
        check(cnt, 1);
        ahb(1'b1, {24'h0, `MCD_REG_CTRL}, 32'h2);
        watch(30);
        check(cnt > 1, 1'b1);
        $display("test halt done");
        ahb(1'b1, {24'h0, `MCD_REG_STACK_LIMIT}, 32'h0);
        for (int i = 0; i < 7; i++) begin
            bus_address <= dec_adr[i];
            repeat (2) @(posedge hclk);
            check(dec_seen, dec_exp[i]);
        end
        $display("test decode done");
        test_done;
    end
endmodule
bind mcd_datapath mcd_monitor #(.UPTR_W(UPTR_W), .DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_mon (
    .hclk, .hresetn, .micro_pointer, .pulse_length_sel0, .pulse_length_sel1, .result_sel,
    .load_instr_enable, .load_addr_enable, .load_operand_b_enable, .write_high_byte,
    .write_low_byte, .addr_clk, .operand_b_clk, .write_high_clk, .write_low_clk,
    .read_bus, .alu_out, .bus_address, .phase_pulse_first,
    .phase_pulse_second, .phase_pulse_third, .instr_clk, .result_clk, .result_select_mux,
    .bus_data_out, .data_display_n, .previous_micro_pointer, .expansion_micro_pointer,
    .sel_processor_status, .stack_overflow_flag, .stack_overflow_halt
);
